// ---- logic/fks_consts.vh ----
// Constants for the fast kinetics sequencer: offsets, fields, resets, timing
`ifndef FKS_CONSTS_VH
`define FKS_CONSTS_VH

`define FKS_OFF_CTRL        8'h00
`define FKS_OFF_SHIFT_ROWS  8'h04
`define FKS_OFF_SERIES_LEN  8'h08
`define FKS_OFF_SUB_POS     8'h0c
`define FKS_OFF_SUB_HEIGHT  8'h10
`define FKS_OFF_EXPOSURE    8'h14
`define FKS_OFF_STATUS      8'h18
`define FKS_OFF_MAX_SERIES  8'h1c

`define FKS_CTRL_START      0
`define FKS_CTRL_TRIG_EXT   1

`define FKS_ST_STATE_LSB    0
`define FKS_ST_BUSY         4
`define FKS_ST_DONE         5
`define FKS_ST_CLAMPED      6
`define FKS_ST_FRAME_LSB    16

`define FKS_RST_SHIFT_ROWS  16'h0010
`define FKS_RST_SERIES_LEN  16'h0004
`define FKS_RST_SUB_POS     16'h0200
`define FKS_RST_SUB_HEIGHT  16'h0010
`define FKS_RST_EXPOSURE    32'h0000_0064

`define FKS_ROWS_DEF        1024
`define FKS_COLS_DEF        512

`define FKS_CLK_MHZ         50
`define FKS_VSHIFT_NS       100
`define FKS_HSHIFT_NS       100
`define FKS_VSHIFT_CYC      ((`FKS_VSHIFT_NS * `FKS_CLK_MHZ + 999) / 1000)
`define FKS_HSHIFT_CYC      ((`FKS_HSHIFT_NS * `FKS_CLK_MHZ + 999) / 1000)

`endif

// ---- logic/fks_sync.v ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fks_sync (
    pclk,
    presetn,
    pin_i,
    level_o
);
    input  wire pclk;
    input  wire presetn;
    input  wire pin_i;
    output wire level_o;

    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg lvl_q;

    // Output follows only once stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end

    assign level_o = lvl_q;
endmodule

// ---- logic/fks_sequencer.v ----
// Fast kinetics burst sequencer with APB register slave
//
// Summary of operation
// - Before acquiring, one complete flush pass empties image and storage rows.
// - On the trigger the flush stops and charge integrates on the sub-area.
// - After the exposure time the whole sensor shifts by the programmed row count.
// - Expose and shift repeat, counting frames, until the series length, capped at the series limit, is stored.
// - Stored frames may occupy the masked storage rows as well as dark image rows.
// - After the series, rows shift until the first frame is at row zero, then lines read out.
// - No flush happens from the trigger until the burst has ended.
// - The series limit comes from sub-area position, sub-area height, shift row count and total rows.
// - A burst starts on an internal trigger or on the external trigger pin.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "fks_consts.vh"
module fks_sequencer #(
    parameter ROWS  = `FKS_ROWS_DEF,
    parameter COLS  = `FKS_COLS_DEF,
    parameter V_CYC = `FKS_VSHIFT_CYC,
    parameter H_CYC = `FKS_HSHIFT_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        ext_trig_i,
    output reg         vshift_o,
    output reg         hshift_o,
    output reg         dump_o,
    output reg         sample_o,
    output reg         busy_o,
    output reg         done_o
);
    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_FLUSH = 4'h1;
    localparam [3:0] S_WAIT  = 4'h2;
    localparam [3:0] S_EXP   = 4'h3;
    localparam [3:0] S_SHIFT = 4'h4;
    localparam [3:0] S_PRE   = 4'h5;
    localparam [3:0] S_RDV   = 4'h6;
    localparam [3:0] S_RDH   = 4'h7;
    localparam [3:0] S_DONE  = 4'h8;
    localparam [15:0] ROWS16  = ROWS[15:0];
    localparam [15:0] COLS16  = COLS[15:0];
    localparam [15:0] VCYC16  = V_CYC[15:0];
    localparam [15:0] HCYC16  = H_CYC[15:0];
    function [15:0] fks_min16;
        input [15:0] a;
        input [15:0] b;
        begin
            fks_min16 = (a < b) ? a : b;
        end
    endfunction
    reg         trig_ext_q;
    reg  [15:0] shift_rows_q;
    reg  [15:0] series_len_q;
    reg  [15:0] sub_pos_q;
    reg  [15:0] sub_height_q;
    reg  [31:0] exposure_q;
    reg         done_flag_q;
    reg         clamped_q;
    reg  [3:0]  state_q;
    reg  [15:0] row_q;
    reg  [15:0] frame_q;
    reg  [15:0] line_q;
    reg  [15:0] pix_q;
    reg  [15:0] pace_q;
    reg  [31:0] exp_q;
    reg  [15:0] eff_n_q;
    reg  [15:0] shift_q;
    reg         ext_lvl_d1_q;
    reg  [31:0] rd_d;
    wire        ext_lvl;
    wire        setup     = psel & ~penable;
    wire        wr_fire   = psel & penable & pready & pwrite;
    wire        start_req = wr_fire & (paddr == `FKS_OFF_CTRL) & pwdata[`FKS_CTRL_START];
    wire        ext_rise  = ext_lvl & ~ext_lvl_d1_q;
    wire [16:0] top_row   = {1'b0, sub_pos_q} + {1'b0, sub_height_q};
    // Overlapping frames would smear, so the shift must cover the sub-area height
    wire        geom_ok   = (shift_rows_q != 16'h0000) && (top_row <= {1'b0, ROWS16}) &&
                            (shift_rows_q >= sub_height_q);
    wire [15:0] quot      = geom_ok ? (sub_pos_q / shift_rows_q) : 16'h0000;
    wire [15:0] max_n     = geom_ok ? (quot + 16'h0001) : 16'h0000;
    wire [15:0] eff_n     = fks_min16(series_len_q, max_n);
    wire [31:0] used_prod = (eff_n_q - 16'h0001) * shift_q;
    wire [15:0] pre_rows  = sub_pos_q - used_prod[15:0];
    wire [31:0] line_prod = eff_n_q * shift_q;
    wire [15:0] read_lines = fks_min16(line_prod[15:0], ROWS16);
    wire [15:0] period    = (state_q == S_RDH) ? HCYC16 : VCYC16;
    wire        tick      = (pace_q == period - 16'h0001);
    wire        trig      = trig_ext_q ? ext_rise : 1'b1;
    wire        run_ok    = (eff_n != 16'h0000);
    fks_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_i   (ext_trig_i),
        .level_o (ext_lvl)
    );
    // Register read mux
    always @* begin
        rd_d = 32'h0000_0000;
        case (paddr)
            `FKS_OFF_CTRL:       rd_d[`FKS_CTRL_TRIG_EXT] = trig_ext_q;
            `FKS_OFF_SHIFT_ROWS: rd_d[15:0] = shift_rows_q;
            `FKS_OFF_SERIES_LEN: rd_d[15:0] = series_len_q;
            `FKS_OFF_SUB_POS:    rd_d[15:0] = sub_pos_q;
            `FKS_OFF_SUB_HEIGHT: rd_d[15:0] = sub_height_q;
            `FKS_OFF_EXPOSURE:   rd_d = exposure_q;
            `FKS_OFF_STATUS: begin
                rd_d[3:0]               = state_q;
                rd_d[`FKS_ST_BUSY]      = busy_o;
                rd_d[`FKS_ST_DONE]      = done_flag_q;
                rd_d[`FKS_ST_CLAMPED]   = clamped_q;
                rd_d[31:16]             = frame_q;
            end
            `FKS_OFF_MAX_SERIES: rd_d[15:0] = max_n;
            default:             rd_d = 32'h0000_0000;
        endcase
    end
    // No wait states: answer is registered during the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ((paddr[1:0] != 2'b00) || (paddr > `FKS_OFF_MAX_SERIES));
            prdata  <= setup ? rd_d : 32'h0000_0000;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_ext_q   <= 1'b0;
            shift_rows_q <= `FKS_RST_SHIFT_ROWS;
            series_len_q <= `FKS_RST_SERIES_LEN;
            sub_pos_q    <= `FKS_RST_SUB_POS;
            sub_height_q <= `FKS_RST_SUB_HEIGHT;
            exposure_q   <= `FKS_RST_EXPOSURE;
        end else if (wr_fire && !pslverr) begin
            case (paddr)
                `FKS_OFF_CTRL:       trig_ext_q   <= pwdata[`FKS_CTRL_TRIG_EXT];
                `FKS_OFF_SHIFT_ROWS: shift_rows_q <= pwdata[15:0];
                `FKS_OFF_SERIES_LEN: series_len_q <= pwdata[15:0];
                `FKS_OFF_SUB_POS:    sub_pos_q    <= pwdata[15:0];
                `FKS_OFF_SUB_HEIGHT: sub_height_q <= pwdata[15:0];
                `FKS_OFF_EXPOSURE:   exposure_q   <= pwdata;
                default:             trig_ext_q   <= trig_ext_q;
            endcase
        end
    end
    // Sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= S_IDLE;
            row_q        <= 16'h0000;
            frame_q      <= 16'h0000;
            line_q       <= 16'h0000;
            pix_q        <= 16'h0000;
            pace_q       <= 16'h0000;
            exp_q        <= 32'h0000_0000;
            eff_n_q      <= 16'h0000;
            shift_q      <= 16'h0000;
            done_flag_q  <= 1'b0;
            clamped_q    <= 1'b0;
            ext_lvl_d1_q <= 1'b0;
            vshift_o     <= 1'b0;
            hshift_o     <= 1'b0;
            dump_o       <= 1'b1;
            sample_o     <= 1'b0;
            busy_o       <= 1'b0;
            done_o       <= 1'b0;
        end else begin
            ext_lvl_d1_q <= ext_lvl;
            vshift_o     <= 1'b0;
            hshift_o     <= 1'b0;
            sample_o     <= 1'b0;
            done_o       <= 1'b0;
            pace_q       <= (tick || state_q == S_EXP) ? 16'h0000 : pace_q + 16'h0001;
            if (start_req) begin
                done_flag_q <= 1'b0;
            end
            case (state_q)
                S_IDLE, S_WAIT: begin
                    dump_o <= 1'b1;
                    busy_o <= (state_q == S_WAIT);
                    // No flush row may slip out on the edge the burst starts
                    if (tick && !(state_q == S_WAIT && trig)) begin
                        vshift_o <= 1'b1;
                        row_q    <= (row_q == ROWS16 - 16'h0001) ? 16'h0000 : row_q + 16'h0001;
                    end
                    if (state_q == S_IDLE && start_req) begin
                        clamped_q <= (series_len_q > max_n) || !run_ok;
                        if (run_ok) begin
                            eff_n_q <= eff_n;
                            shift_q <= shift_rows_q;
                            row_q   <= 16'h0000;
                            pace_q  <= 16'h0000;
                            busy_o  <= 1'b1;
                            state_q <= S_FLUSH;
                        end
                    end else if (state_q == S_WAIT && trig) begin
                        dump_o  <= 1'b0;
                        exp_q   <= 32'h0000_0000;
                        frame_q <= 16'h0000;
                        state_q <= S_EXP;
                    end
                end
                S_FLUSH: begin
                    if (tick) begin
                        vshift_o <= 1'b1;
                        row_q    <= row_q + 16'h0001;
                        if (row_q == ROWS16 - 16'h0001) begin
                            row_q   <= 16'h0000;
                            state_q <= S_WAIT;
                        end
                    end
                end
                S_EXP: begin
                    exp_q <= exp_q + 32'h0000_0001;
                    if (exp_q + 32'h0000_0001 >= exposure_q) begin
                        row_q   <= 16'h0000;
                        state_q <= S_SHIFT;
                    end
                end
                S_SHIFT: begin
                    if (tick) begin
                        vshift_o <= 1'b1;
                        row_q    <= row_q + 16'h0001;
                        if (row_q == shift_q - 16'h0001) begin
                            frame_q <= frame_q + 16'h0001;
                            row_q   <= 16'h0000;
                            if (frame_q + 16'h0001 == eff_n_q) begin
                                line_q  <= 16'h0000;
                                state_q <= (pre_rows == 16'h0000) ? S_RDV : S_PRE;
                            end else begin
                                exp_q   <= 32'h0000_0000;
                                state_q <= S_EXP;
                            end
                        end
                    end
                end
                S_PRE: begin
                    if (tick) begin
                        vshift_o <= 1'b1;
                        row_q    <= row_q + 16'h0001;
                        if (row_q == pre_rows - 16'h0001) begin
                            line_q  <= 16'h0000;
                            state_q <= S_RDV;
                        end
                    end
                end
                S_RDV: begin
                    if (tick) begin
                        vshift_o <= 1'b1;
                        pix_q    <= 16'h0000;
                        state_q  <= S_RDH;
                    end
                end
                S_RDH: begin
                    if (tick) begin
                        hshift_o <= 1'b1;
                        sample_o <= 1'b1;
                        pix_q    <= pix_q + 16'h0001;
                        if (pix_q == COLS16 - 16'h0001) begin
                            line_q <= line_q + 16'h0001;
                            if (line_q == read_lines - 16'h0001) begin
                                state_q <= S_DONE;
                            end else begin
                                state_q <= S_RDV;
                            end
                        end
                    end
                end
                S_DONE: begin
                    done_o      <= 1'b1;
                    done_flag_q <= 1'b1;
                    busy_o      <= 1'b0;
                    dump_o      <= 1'b1;
                    row_q       <= 16'h0000;
                    state_q     <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- verif/fks_seq_sva.sv ----
// Port-level checker for the fast kinetics sequencer
`timescale 1ns/1ps
module fks_seq_sva #(
    parameter V_CYC = 5,
    parameter H_CYC = 5
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        ext_trig_i,
    input wire        vshift_o,
    input wire        hshift_o,
    input wire        dump_o,
    input wire        sample_o,
    input wire        busy_o,
    input wire        done_o
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [7:0] vgap_q;
    reg [7:0] hgap_q;
    // Gap counters saturate so long idle stretches never wrap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vgap_q <= 8'hff;
            hgap_q <= 8'hff;
        end else begin
            vgap_q <= vshift_o ? 8'h01 : (vgap_q == 8'hff ? vgap_q : vgap_q + 8'h01);
            hgap_q <= hshift_o ? 8'h01 : (hgap_q == 8'hff ? hgap_q : hgap_q + 8'h01);
        end
    end
    wire bad_addr = (paddr[1:0] != 2'b00) || (paddr > 8'h1c);
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready missing after setup");
    property p_ready_once; pready |=> !pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready held too long");
    property p_err; psel && !penable && bad_addr |=> pslverr && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad address not refused");
    property p_no_err; psel && !penable && !bad_addr |=> !pslverr; endproperty
    a_no_err: assert property (p_no_err) else $error("good address refused");
    property p_idle_zero; !pready |-> prdata == 32'h0; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data outside access");
    property p_pair; hshift_o |-> sample_o; endproperty
    a_pair: assert property (p_pair) else $error("pixel shift without sample");
    property p_hread; hshift_o |-> !dump_o && busy_o; endproperty
    a_hread: assert property (p_hread) else $error("readout outside burst");
    property p_burst_start; $fell(dump_o) |-> busy_o; endproperty
    a_burst_start: assert property (p_burst_start) else $error("flush stop while idle");
    property p_vgap; vshift_o |-> vgap_q >= V_CYC; endproperty
    a_vgap: assert property (p_vgap) else $error("vertical shifts too close");
    property p_hgap; hshift_o |-> hgap_q >= H_CYC; endproperty
    a_hgap: assert property (p_hgap) else $error("horizontal shifts too close");
    property p_done; done_o |=> !done_o ##[0:4] dump_o; endproperty
    a_done: assert property (p_done) else $error("no return to flush after done");
    c_done: cover property (done_o);
    c_err: cover property (pslverr);
    c_burst: cover property ($fell(dump_o));
    c_read: cover property (hshift_o);
endmodule
bind fks_sequencer fks_seq_sva #(.V_CYC(V_CYC), .H_CYC(H_CYC)) fks_seq_sva_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trig_i(ext_trig_i), .vshift_o(vshift_o), .hshift_o(hshift_o), .dump_o(dump_o),
    .sample_o(sample_o), .busy_o(busy_o), .done_o(done_o));

// ---- verif/fks_sensor_model.sv ----
// Sensor clock driver model: counts row and pixel shifts, drives trigger pin
`timescale 1ns/1ps
module fks_sensor_model (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        vshift_i,
    input  wire        hshift_i,
    input  wire        sample_i,
    input  wire        dump_i,
    input  wire        clr_i,
    input  wire        trig_i,
    output reg         ext_trig_o,
    output reg  [15:0] vb_cnt_o,
    output reg  [15:0] vf_cnt_o,
    output reg  [15:0] h_cnt_o,
    output reg  [15:0] s_cnt_o
);
    // Dump level splits flush shifts from stored-frame shifts
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || clr_i) begin
            vb_cnt_o <= 16'h0;
            vf_cnt_o <= 16'h0;
            h_cnt_o  <= 16'h0;
            s_cnt_o  <= 16'h0;
        end else begin
            if (vshift_i && dump_i) vf_cnt_o <= vf_cnt_o + 16'h1;
            if (vshift_i && !dump_i) vb_cnt_o <= vb_cnt_o + 16'h1;
            if (hshift_i) h_cnt_o <= h_cnt_o + 16'h1;
            if (sample_i) s_cnt_o <= s_cnt_o + 16'h1;
        end
    end
    // Trigger pin changes on the clock, unrelated to the sequencer state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) ext_trig_o <= 1'b0;
        else ext_trig_o <= trig_i;
    end
endmodule

// ---- verif/fks_sequencer_bench.sv ----
// Self-checking bench for the fast kinetics sequencer
`timescale 1ns/1ps
`include "fks_consts.vh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module fks_sequencer_bench;
    localparam ROWS = 32;
    localparam COLS = 4;
    reg         pclk, presetn, psel, penable, pwrite, clr, trig, er;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, ext_trig, vshift, hshift, dump, sample, busy, done;
    wire [15:0] vb_cnt, vf_cnt, h_cnt, s_cnt;
    integer     num_errors = 0, tests_run = 0, seed = 32'h2aed90a6, i, lines;
    fks_sequencer #(.ROWS(ROWS), .COLS(COLS), .V_CYC(2), .H_CYC(2)) fks_sequencer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_trig_i(ext_trig), .vshift_o(vshift), .hshift_o(hshift), .dump_o(dump),
        .sample_o(sample), .busy_o(busy), .done_o(done));
    fks_sensor_model fks_sensor_model_i (
        .pclk(pclk), .presetn(presetn), .vshift_i(vshift), .hshift_i(hshift),
        .sample_i(sample), .dump_i(dump), .clr_i(clr), .trig_i(trig), .ext_trig_o(ext_trig),
        .vb_cnt_o(vb_cnt), .vf_cnt_o(vf_cnt), .h_cnt_o(h_cnt), .s_cnt_o(s_cnt));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task end_of_test;
        begin
            $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge pclk);
            psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0; penable <= 1'b0;
            if (k >= 20) begin num_errors++; end_of_test; end
        end
    endtask
    function [31:0] rst_exp(input [7:0] a);
        case (a)
            `FKS_OFF_SHIFT_ROWS: rst_exp = `FKS_RST_SHIFT_ROWS;
            `FKS_OFF_SERIES_LEN: rst_exp = `FKS_RST_SERIES_LEN;
            `FKS_OFF_SUB_POS:    rst_exp = `FKS_RST_SUB_POS;
            `FKS_OFF_SUB_HEIGHT: rst_exp = `FKS_RST_SUB_HEIGHT;
            `FKS_OFF_EXPOSURE:   rst_exp = `FKS_RST_EXPOSURE;
            default:             rst_exp = 32'h0;
        endcase
    endfunction
    // Sub-area sits three frames up, so the limit is always four frames
    task burst(input integer sr, input integer len, input integer t, input integer ext);
        integer n, k;
        begin
            apb(1, `FKS_OFF_SHIFT_ROWS, sr); apb(1, `FKS_OFF_SUB_POS, 3 * sr);
            apb(1, `FKS_OFF_SUB_HEIGHT, sr); apb(1, `FKS_OFF_SERIES_LEN, len);
            apb(1, `FKS_OFF_EXPOSURE, t); apb(0, `FKS_OFF_MAX_SERIES, 0);
            `CHK("max_series", 32'h4, rd)
            n = (len > 4) ? 4 : len;
            lines = (n * sr < ROWS) ? n * sr : ROWS;
            @(posedge pclk) clr <= 1'b1;
            @(posedge pclk) clr <= 1'b0;
            apb(1, `FKS_OFF_CTRL, ext ? 32'h3 : 32'h1);
            if (ext) begin
                repeat (200) @(posedge pclk);
                `CHK("busy_wait", 1'b1, busy)
                `CHK("dump_wait", 1'b1, dump)
                @(posedge pclk) trig <= 1'b1;
                repeat (8) @(posedge pclk);
                trig <= 1'b0;
            end
            k = 0;
            do begin @(posedge pclk); k++; end while (done !== 1'b1 && k < 20000);
            if (k >= 20000) begin num_errors++; end_of_test; end
            repeat (3) @(posedge pclk);
            `CHK("flush_pass", 1'b1, vf_cnt >= ROWS)
            `CHK("burst_vshift", n * sr + (3 - n + 1) * sr + lines, vb_cnt)
            `CHK("hshift", lines * COLS, h_cnt)
            `CHK("sample", lines * COLS, s_cnt)
            apb(0, `FKS_OFF_STATUS, 0);
            `CHK("st_busy", 1'b0, rd[`FKS_ST_BUSY])
            `CHK("st_done", 1'b1, rd[`FKS_ST_DONE])
            `CHK("st_clamp", len > 4, rd[`FKS_ST_CLAMPED])
            `CHK("st_frames", n, rd[31:16])
        end
    endtask
    initial begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
        clr = 1'b0; trig = 1'b0; presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 32; i = i + 4) begin
            if (i != `FKS_OFF_STATUS) begin
                apb(0, i, 0);
                `CHK("reset_value", rst_exp(i), rd)
                `CHK("reset_err", 1'b0, er)
            end
        end
        apb(0, 8'h20, 0);
        `CHK("unmapped_err", 1'b1, er)
        `CHK("unmapped_data", 32'h0, rd)
        apb(0, 8'h02, 0);
        `CHK("unaligned_err", 1'b1, er)
        // Sub-area taller than a frame shift leaves no legal series
        apb(1, `FKS_OFF_SHIFT_ROWS, 4); apb(1, `FKS_OFF_SUB_POS, 12);
        apb(1, `FKS_OFF_SUB_HEIGHT, 8); apb(0, `FKS_OFF_MAX_SERIES, 0);
        `CHK("max_zero", 32'h0, rd)
        apb(1, `FKS_OFF_CTRL, 1);
        repeat (5) @(posedge pclk);
        `CHK("start_refused", 1'b0, busy)
        apb(0, `FKS_OFF_STATUS, 0);
        `CHK("refused_clamp", 1'b1, rd[`FKS_ST_CLAMPED])
        for (i = 0; i < 3; i = i + 1)
            burst(($random(seed) & 1) ? 8 : 4, 1 + {$random(seed)} % 4,
                  1 + {$random(seed)} % 16, 0);
        burst(4, 7, 1, 0);
        burst(8, 4, 3, 1);
        end_of_test;
    end
endmodule
